// ===== hdl/ems_map.vh
`ifndef EMS_MAP_VH
`define EMS_MAP_VH
`define EMS_ADDR_SOFTRST 8'h00
`define EMS_ADDR_CTRL_HUM 8'h04
`define EMS_ADDR_STATUS 8'h08
`define EMS_ADDR_CTRL_MEAS 8'h0C
`define EMS_ADDR_CONFIG 8'h10
`define EMS_ADDR_TEMP 8'h14
`define EMS_ADDR_PRES 8'h18
`define EMS_ADDR_HUM 8'h1C
`define EMS_ADDR_ADC_T 8'h20
`define EMS_ADDR_ADC_P 8'h24
`define EMS_ADDR_ADC_H 8'h28
`define EMS_ADDR_CHIP_ID 8'h2C
`define EMS_SOFTRST_KEY 8'hB6
`define EMS_MODE_SLEEP 2'h0
`define EMS_MODE_NORMAL 2'h3
`define EMS_MEAS_MODE_LSB 0
`define EMS_MEAS_OSP_LSB 2
`define EMS_MEAS_OST_LSB 5
`define EMS_CFG_FILT_LSB 2
`define EMS_CFG_SB_LSB 5
`define EMS_SKIP_VALUE 20'h80000
`define EMS_HUM_SKIP 16'h8000
`define EMS_CONV_US 100
`define EMS_CLK_MHZ 20
`define EMS_RESP_OKAY 2'h0
`define EMS_RESP_SLVERR 2'h2
`endif

// ===== hdl/ems_sequencer.v
// Operation
// - Power-on reset clears logic and registers
// - After any reset, sleep with no activity
// - Soft reset command acts as power-on reset; here the AXI port and ADC synchronisers keep their state
// - Two-bit mode selects sleep, forced, normal
// - Sleep measures nothing, registers stay accessible
// - Mode change waits for measurement end
// - Pending change discards mode, humidity writes
// - Forced runs one measurement then sleeps
// - Normal alternates measurement and standby periods
// - Three-bit field sets standby 0.5-1000 ms
// - Data registers hold latest completed results
// - Temperature, pressure, humidity conversions each period
// - Filter only pressure, temperature; humidity bypasses
// - Humidity field enables, oversamples; 16-bit result
// - Pressure width 20 filtered, else 16+osrs-1
// - Temperature width 20 filtered, else 16+osrs-1
// - Filter: (old*(c-1)+new)/c, c in 1..16
// - Filter result updates state and output
// - Filter write resets; next sample loads state
// - Skipped conversion reads 0x80000, state kept
// - Re-enabled conversion resumes retained state
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "ems_map.vh"
module ems_sequencer #(
  parameter SB_SCALE = 1
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [19:0] adc_temp,
  input wire [19:0] adc_pres,
  input wire [15:0] adc_hum,
  output wire measuring,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [7:0] CHIP_ID = 8'h5A; // Arbitrary value
  localparam [31:0] CONV_CYC = `EMS_CONV_US * `EMS_CLK_MHZ;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_FILT = 2'h2;
  localparam [1:0] ST_WAIT = 2'h3;

  // Standby in cycles; 0.5 ms to 1000 ms at 20 MHz, scaled for simulation
  function [31:0] sb_cycles;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: sb_cycles = 32'd10000;
        3'h1: sb_cycles = 32'd1250000;
        3'h2: sb_cycles = 32'd2500000;
        3'h3: sb_cycles = 32'd5000000;
        3'h4: sb_cycles = 32'd10000000;
        3'h5: sb_cycles = 32'd20000000;
        3'h6: sb_cycles = 32'd200000;
        default: sb_cycles = 32'd400000;
      endcase
      sb_cycles = sb_cycles / SB_SCALE;
      if (sb_cycles == 32'd0) sb_cycles = 32'd1;
    end
  endfunction

  // Oversampling multiplier; 0 means skipped
  function [4:0] os_mult;
    input [2:0] os;
    begin
      case (os)
        3'h0: os_mult = 5'd0;
        3'h1: os_mult = 5'd1;
        3'h2: os_mult = 5'd2;
        3'h3: os_mult = 5'd4;
        3'h4: os_mult = 5'd8;
        default: os_mult = 5'd16;
      endcase
    end
  endfunction

  // Filter: (old*(c-1)+new)/c, c = 2^k, truncating
  function [19:0] iir;
    input [19:0] old;
    input [19:0] smp;
    input [2:0] k;
    reg [24:0] acc;
    reg [24:0] quo;
    begin
      acc = ({5'd0, old} << k) - {5'd0, old} + {5'd0, smp};
      quo = acc >> k;
      iir = quo[19:0];
    end
  endfunction

  // Unfiltered width 16+osrs-1: drop unused low bits
  function [19:0] trunc_res;
    input [19:0] v;
    input [2:0] os;
    reg [19:0] m;
    begin
      m = 20'hFFFFF;
      if (os < 3'h5) m = 20'hFFFFF << (3'h5 - os);
      trunc_res = v & m;
    end
  endfunction

  reg [2:0] ctrl_hum;
  reg [2:0] hum_active;
  reg [7:0] ctrl_meas;
  reg [7:0] pend_meas;
  reg pending;
  reg [7:0] config_reg;
  reg [19:0] temp_out;
  reg [19:0] pres_out;
  reg [15:0] hum_out;
  reg [19:0] filt_t;
  reg [19:0] filt_p;
  reg filt_init_t;
  reg filt_init_p;
  reg [1:0] state;
  reg [31:0] count;
  reg [1:0] run_mode;
  reg soft_rst;
  reg [19:0] adc_t_s1;
  reg [19:0] adc_t_s2;
  reg [19:0] adc_p_s1;
  reg [19:0] adc_p_s2;
  reg [15:0] adc_h_s1;
  reg [15:0] adc_h_s2;
  reg aw_held;
  reg [7:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire [2:0] os_t = ctrl_meas[`EMS_MEAS_OST_LSB +: 3];
  wire [2:0] os_p = ctrl_meas[`EMS_MEAS_OSP_LSB +: 3];
  wire [2:0] filt_k = config_reg[`EMS_CFG_FILT_LSB +: 3] > 3'h4 ?
    3'h4 : config_reg[`EMS_CFG_FILT_LSB +: 3];
  wire [2:0] sb_sel = config_reg[`EMS_CFG_SB_LSB +: 3];
  wire busy = (state == ST_CONV) || (state == ST_FILT);
  wire [31:0] conv_len = CONV_CYC * (1 + {27'd0, os_mult(os_t)} +
    {27'd0, os_mult(os_p)} + {27'd0, os_mult(hum_active)});
  assign measuring = busy;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_ok = aw_held || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_held || (s_axi_wvalid && s_axi_wready);
  wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
  wire wr_go = aw_ok && w_ok && !s_axi_bvalid;
  wire wr_b0 = wr_go && ws[0];
  wire wr_map = wa == `EMS_ADDR_SOFTRST || wa == `EMS_ADDR_CTRL_HUM ||
    wa == `EMS_ADDR_CTRL_MEAS || wa == `EMS_ADDR_CONFIG;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EMS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `EMS_RESP_OKAY : `EMS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    if (s_axi_araddr == `EMS_ADDR_CTRL_HUM) begin
      next_rdata = {29'd0, ctrl_hum};
    end else if (s_axi_araddr == `EMS_ADDR_STATUS) begin
      next_rdata = {28'd0, busy, 2'd0, pending};
    end else if (s_axi_araddr == `EMS_ADDR_CTRL_MEAS) begin
      next_rdata = {24'd0, ctrl_meas};
    end else if (s_axi_araddr == `EMS_ADDR_CONFIG) begin
      next_rdata = {24'd0, config_reg};
    end else if (s_axi_araddr == `EMS_ADDR_TEMP) begin
      next_rdata = {12'd0, temp_out};
    end else if (s_axi_araddr == `EMS_ADDR_PRES) begin
      next_rdata = {12'd0, pres_out};
    end else if (s_axi_araddr == `EMS_ADDR_HUM) begin
      next_rdata = {16'd0, hum_out};
    end else if (s_axi_araddr == `EMS_ADDR_CHIP_ID) begin
      next_rdata = {24'd0, CHIP_ID};
    end
  end
  wire rd_map = s_axi_araddr == `EMS_ADDR_CTRL_HUM ||
    s_axi_araddr == `EMS_ADDR_STATUS || s_axi_araddr == `EMS_ADDR_SOFTRST ||
    s_axi_araddr == `EMS_ADDR_CTRL_MEAS ||
    s_axi_araddr == `EMS_ADDR_CONFIG || s_axi_araddr == `EMS_ADDR_TEMP ||
    s_axi_araddr == `EMS_ADDR_PRES || s_axi_araddr == `EMS_ADDR_HUM ||
    s_axi_araddr == `EMS_ADDR_CHIP_ID;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EMS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_map ? `EMS_RESP_OKAY : `EMS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ADC values come from the analog side: two-stage synchronisers
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      adc_t_s1 <= 20'h00000;
      adc_t_s2 <= 20'h00000;
      adc_p_s1 <= 20'h00000;
      adc_p_s2 <= 20'h00000;
      adc_h_s1 <= 16'h0000;
      adc_h_s2 <= 16'h0000;
    end else begin
      adc_t_s1 <= adc_temp;
      adc_t_s2 <= adc_t_s1;
      adc_p_s1 <= adc_pres;
      adc_p_s2 <= adc_p_s1;
      adc_h_s1 <= adc_hum;
      adc_h_s2 <= adc_h_s1;
    end
  end

  wire mode_wr = wr_b0 && wa == `EMS_ADDR_CTRL_MEAS;
  wire [1:0] new_mode = wd[`EMS_MEAS_MODE_LSB +: 2];
  // A write in the filter cycle with no change pending is taken at once, never left pending
  wire [7:0] pend_src = pending ? pend_meas : wd[7:0];
  // Soft reset is registered so sequencer registers clear one cycle later; AXI port and synchronisers keep state
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_b0 && wa == `EMS_ADDR_SOFTRST &&
        wd[7:0] == `EMS_SOFTRST_KEY;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_hum <= 3'h0;
      hum_active <= 3'h0;
      ctrl_meas <= 8'h00;
      pend_meas <= 8'h00;
      pending <= 1'b0;
      config_reg <= 8'h00;
      temp_out <= `EMS_SKIP_VALUE;
      pres_out <= `EMS_SKIP_VALUE;
      hum_out <= `EMS_HUM_SKIP;
      filt_t <= 20'h00000;
      filt_p <= 20'h00000;
      filt_init_t <= 1'b1;
      filt_init_p <= 1'b1;
      state <= ST_IDLE;
      count <= 32'd0;
      run_mode <= `EMS_MODE_SLEEP;
    end else if (soft_rst) begin
      ctrl_hum <= 3'h0;
      hum_active <= 3'h0;
      ctrl_meas <= 8'h00;
      pend_meas <= 8'h00;
      pending <= 1'b0;
      config_reg <= 8'h00;
      temp_out <= `EMS_SKIP_VALUE;
      pres_out <= `EMS_SKIP_VALUE;
      hum_out <= `EMS_HUM_SKIP;
      filt_t <= 20'h00000;
      filt_p <= 20'h00000;
      filt_init_t <= 1'b1;
      filt_init_p <= 1'b1;
      state <= ST_IDLE;
      count <= 32'd0;
      run_mode <= `EMS_MODE_SLEEP;
    end else begin
      if (wr_b0 && wa == `EMS_ADDR_CTRL_HUM && !pending) begin
        ctrl_hum <= wd[2:0];
      end
      if (mode_wr && !pending) begin
        if (busy) begin
          pending <= 1'b1;
          pend_meas <= wd[7:0];
        end else begin
          ctrl_meas <= wd[7:0];
          run_mode <= new_mode;
          count <= 32'd0;
          state <= (new_mode == `EMS_MODE_SLEEP) ? ST_IDLE : ST_CONV;
          hum_active <= ctrl_hum;
        end
      end
      case (state)
        ST_CONV: begin
          count <= count + 32'd1;
          if (count + 32'd1 >= conv_len) begin
            state <= ST_FILT;
          end
        end
        ST_FILT: begin
          count <= 32'd0;
          if (os_t == 3'h0) begin
            temp_out <= `EMS_SKIP_VALUE;
          end else if (filt_k == 3'h0) begin
            temp_out <= trunc_res(adc_t_s2, os_t);
          end else if (filt_init_t) begin
            filt_t <= adc_t_s2;
            temp_out <= adc_t_s2;
            filt_init_t <= 1'b0;
          end else begin
            filt_t <= iir(filt_t, adc_t_s2, filt_k);
            temp_out <= iir(filt_t, adc_t_s2, filt_k);
          end
          if (os_p == 3'h0) begin
            pres_out <= `EMS_SKIP_VALUE;
          end else if (filt_k == 3'h0) begin
            pres_out <= trunc_res(adc_p_s2, os_p);
          end else if (filt_init_p) begin
            filt_p <= adc_p_s2;
            pres_out <= adc_p_s2;
            filt_init_p <= 1'b0;
          end else begin
            filt_p <= iir(filt_p, adc_p_s2, filt_k);
            pres_out <= iir(filt_p, adc_p_s2, filt_k);
          end
          hum_out <= (hum_active == 3'h0) ? `EMS_HUM_SKIP :
            adc_h_s2;
          if (pending || mode_wr) begin
            pending <= 1'b0;
            ctrl_meas <= pend_src;
            run_mode <= pend_src[`EMS_MEAS_MODE_LSB +: 2];
            hum_active <= ctrl_hum;
            if (pend_src[`EMS_MEAS_MODE_LSB +: 2] == `EMS_MODE_SLEEP) begin
              state <= ST_IDLE;
            end else if (pend_src[`EMS_MEAS_MODE_LSB +: 2] ==
                `EMS_MODE_NORMAL) begin
              state <= ST_WAIT;
            end else begin
              state <= ST_CONV;
            end
          end else if (run_mode == `EMS_MODE_NORMAL) begin
            state <= ST_WAIT;
          end else begin
            state <= ST_IDLE;
            ctrl_meas[`EMS_MEAS_MODE_LSB +: 2] <= `EMS_MODE_SLEEP;
            run_mode <= `EMS_MODE_SLEEP;
          end
        end
        ST_WAIT: begin
          count <= mode_wr ? 32'd0 : count + 32'd1;
          if (count + 32'd1 >= sb_cycles(sb_sel) && !mode_wr) begin
            count <= 32'd0;
            state <= ST_CONV;
            hum_active <= ctrl_hum;
          end
        end
      endcase
      if (wr_b0 && wa == `EMS_ADDR_CONFIG) begin
        config_reg <= wd[7:0];
        filt_init_t <= 1'b1;
        filt_init_p <= 1'b1;
      end
    end
  end
endmodule // ems_sequencer

// ===== bench/ems_seq_monitor.sv
`timescale 1ns/1ps
`include "ems_map.vh"
module ems_seq_monitor (
  input logic clk_sys,
  input logic reset_n,
  input logic measuring,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire ar_hit = s_axi_arvalid && s_axi_arready;
  wire w_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Unmapped means no register answers at that byte address
  wire ar_bad = !(s_axi_araddr inside {`EMS_ADDR_SOFTRST, `EMS_ADDR_CTRL_HUM,
    `EMS_ADDR_STATUS, `EMS_ADDR_CTRL_MEAS, `EMS_ADDR_CONFIG, `EMS_ADDR_TEMP,
    `EMS_ADDR_PRES, `EMS_ADDR_HUM, `EMS_ADDR_CHIP_ID});
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken");
  property p_r_lat;
    ar_hit |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    w_hit |=> s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_r_err;
    ar_hit && ar_bad |=> s_axi_rresp == `EMS_RESP_SLVERR && s_axi_rdata == 0;
  endproperty
  a_r_err: assert property (p_r_err) else $error("no read error");
  property p_r_ok;
    ar_hit && !ar_bad |=> s_axi_rresp == `EMS_RESP_OKAY;
  endproperty
  a_r_ok: assert property (p_r_ok) else $error("bad read resp");
  property p_rst_idle;
    $rose(reset_n) |-> !measuring [*4];
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy at rst");
  // A conversion lasts far longer than eight cycles
  property p_conv_min;
    $rose(measuring) |-> measuring [*8];
  endproperty
  a_conv_min: assert property (p_conv_min) else $error("short conv");
  c_done: cover property ($fell(measuring));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `EMS_RESP_SLVERR);
  c_pend: cover property (s_axi_rvalid && s_axi_rdata[0] && s_axi_rdata[3]);
endmodule // ems_seq_monitor

// ===== bench/ems_adc_model.sv
`timescale 1ns/1ps
module ems_adc_model (
  input wire clk_sys,
  output logic [19:0] adc_temp,
  output logic [19:0] adc_pres,
  output logic [15:0] adc_hum
);
  // Values move only between shots, so results are predictable
  initial begin
    adc_temp = 20'h00000;
    adc_pres = 20'h00000;
    adc_hum = 16'h0000;
  end
  task automatic load(input logic [19:0] t, p, input logic [15:0] h);
    @(posedge clk_sys);
    adc_temp <= t;
    adc_pres <= p;
    adc_hum <= h;
  endtask
endmodule // ems_adc_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`include "ems_map.vh"
module tb_top;
  localparam logic [31:0] CHIP_ID = 32'h0000005A;
  localparam logic [31:0] SKIP = {12'h000, `EMS_SKIP_VALUE};
  logic [19:0] tv [5] = '{20'h12345, 20'h2468B, 20'h40001, 20'h40010,
    20'h40020};
  logic [19:0] pv [5] = '{20'h6789A, 20'h13579, 20'h30003, 20'h30033,
    20'h30300};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [19:0] adc_temp, adc_pres;
  wire [15:0] adc_hum;
  wire measuring;
  int failures = 0;
  int n_checks = 0;
  int gap;
  logic [1:0] wr_resp, rr;
  logic [31:0] rd;
  logic [20:0] st, sp;
  always #25 clk_sys = ~clk_sys;
  ems_adc_model i_adc (.clk_sys(clk_sys), .adc_temp(adc_temp),
    .adc_pres(adc_pres), .adc_hum(adc_hum));
  ems_sequencer #(.SB_SCALE(1000)) i_dut (.clk_sys(clk_sys),
    .reset_n(reset_n), .adc_temp(adc_temp), .adc_pres(adc_pres),
    .adc_hum(adc_hum), .measuring(measuring), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ready is sampled at the falling edge, acted on at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ak, wk, bk;
    bk = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bk) begin
      @(negedge clk_sys);
      ak = s_axi_awvalid && s_axi_awready;
      wk = s_axi_wvalid && s_axi_wready;
      bk = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge clk_sys);
      if (ak) s_axi_awvalid <= 1'b0;
      if (wk) s_axi_wvalid <= 1'b0;
      if (bk) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic ak, rk;
    rk = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rk) begin
      @(negedge clk_sys);
      ak = s_axi_arvalid && s_axi_arready;
      rk = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk_sys);
      if (ak) s_axi_arvalid <= 1'b0;
      if (rk) s_axi_rready <= 1'b0;
    end
    chk(rd, exp);
  endtask
  task automatic wait_meas(input logic lv, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (measuring !== lv && n < 20000);
    chk({31'h0, measuring}, {31'h0, lv});
  endtask
  task automatic shot(input logic [31:0] meas);
    wr(8'h0C, meas);
    wait_meas(1'b1, gap);
    wait_meas(1'b0, gap);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    rchk(8'h14, SKIP);
    rchk(8'h18, SKIP);
    rchk(8'h1C, {16'h0, `EMS_HUM_SKIP});
    rchk(8'h08, 32'h0);
    rchk(8'h2C, CHIP_ID);
    rchk(8'h40, 32'h0);
    chk({30'h0, rr}, {30'h0, `EMS_RESP_SLVERR});
    wr(8'h40, 32'h1);
    chk({30'h0, wr_resp}, {30'h0, `EMS_RESP_SLVERR});
    i_adc.load(tv[0], pv[0], 16'hBEEF);
    wr(8'h04, 32'h1);
    chk({30'h0, wr_resp}, {30'h0, `EMS_RESP_OKAY});
    wr(8'h0C, 32'h25);
    wait_meas(1'b1, gap);
    wr(8'h0C, 32'h27);
    rchk(8'h08, 32'h9);
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h24);
    wait_meas(1'b0, gap);
    i_adc.load(tv[1], pv[1], 16'h1234);
    rchk(8'h0C, 32'h27);
    rchk(8'h14, {12'h0, tv[0] & 20'hFFFF0});
    rchk(8'h18, {12'h0, pv[0] & 20'hFFFF0});
    rchk(8'h1C, 32'h0000BEEF);
    wait_meas(1'b1, gap);
    wait_meas(1'b0, gap);
    wait_meas(1'b1, gap);
    chk({31'h0, gap >= 5 && gap <= 20}, 32'h1);
    wait_meas(1'b0, gap);
    rchk(8'h14, {12'h0, tv[1] & 20'hFFFF0});
    rchk(8'h1C, 32'h00001234);
    wr(8'h0C, 32'h24);
    wait_meas(1'b0, gap);
    gap = 0;
    repeat (300) begin
      @(negedge clk_sys);
      if (measuring !== 1'b0) gap++;
    end
    chk(gap, 32'h0);
    rchk(8'h0C, 32'h24);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h04);
    i_adc.load(tv[2], pv[2], 16'h1234);
    shot(32'h26);
    st = {1'b0, tv[2]};
    sp = {1'b0, pv[2]};
    rchk(8'h14, {11'h0, st});
    rchk(8'h18, {11'h0, sp});
    rchk(8'h1C, {16'h0, `EMS_HUM_SKIP});
    i_adc.load(tv[3], pv[3], 16'h1234);
    shot(32'h25);
    st = (st + tv[3]) >> 1;
    sp = (sp + pv[3]) >> 1;
    rchk(8'h14, {11'h0, st});
    rchk(8'h18, {11'h0, sp});
    i_adc.load(tv[4], pv[4], 16'h1234);
    shot(32'h05);
    sp = (sp + pv[4]) >> 1;
    rchk(8'h14, SKIP);
    rchk(8'h18, {11'h0, sp});
    wr(8'h04, 32'h1);
    shot(32'h25);
    st = (st + tv[4]) >> 1;
    rchk(8'h14, {11'h0, st});
    rchk(8'h1C, 32'h00001234);
    wr(8'h10, 32'h10);
    shot(32'h05);
    rchk(8'h18, {12'h0, pv[4]});
    i_adc.load(tv[0], pv[0], 16'h1234);
    shot(32'h05);
    sp = 21'((25'(pv[4]) * 25'd15 + 25'(pv[0])) >> 4);
    rchk(8'h18, {11'h0, sp});
    wr(8'h00, {24'h0, `EMS_SOFTRST_KEY});
    repeat (2) @(posedge clk_sys);
    rchk(8'h10, 32'h0);
    rchk(8'h14, SKIP);
    report_and_stop;
  end
  initial begin
    repeat (80000) @(posedge clk_sys);
    failures++;
    report_and_stop;
  end
endmodule // tb_top
bind ems_sequencer ems_seq_monitor i_mon (.clk_sys(clk_sys),
  .reset_n(reset_n), .measuring(measuring),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
